// *** mqaf_pkg.sv ***
// Constants shared by the multi-queue almost-flag block.
// Assumes a single 50 MHz clock and a plain register port with 32-bit words.
package mqaf_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned NUM_QUEUES = 32;
  localparam int unsigned QUEUE_DEPTH = 512;
  localparam int unsigned QSEL_W = 5;
  localparam int unsigned BUS_GROUP = 8;
  // Register word addresses.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PROG = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_CLEAR = 4'h3;
  localparam logic [3:0] REG_ENABLE = 4'h4;
  localparam logic [3:0] REG_LEVEL = 4'h5;
  // Control fields.
  localparam int unsigned CTRL_DEF_SEL_BIT = 0;
  localparam int unsigned CTRL_LOAD_BIT = 1;
  // Programming fields.
  localparam int unsigned PROG_QUEUE_LSB = 0;
  localparam int unsigned PROG_KIND_BIT = 8;
  localparam int unsigned PROG_VALUE_LSB = 16;
  localparam int unsigned PROG_VALUE_W = 16;
  // Event bits in status, clear and enable.
  localparam int unsigned EV_AF_BIT = 0;
  localparam int unsigned EV_AE_BIT = 1;
  localparam int unsigned EV_W = 2;
  // Default offsets.
  localparam logic [15:0] DEF_OFFSET_SMALL = 16'h0008;
  localparam logic [15:0] DEF_OFFSET_LARGE = 16'h0080;
  // Selection latency in port clock edges.
  localparam int unsigned SEL_FLAG_EDGES = 1;
  localparam int unsigned SEL_PORT_EDGES = 3;
endpackage : mqaf_pkg

// *** mqaf_qsel.sv ***
// Queue selection pipeline for one port.
// Assumes tick marks the port clock edge and the strobe is sampled only then.
`timescale 1ns/1ps
`default_nettype none
module mqaf_qsel
  import mqaf_pkg::*;
#(
  parameter int unsigned QW = QSEL_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic strobe,
  input wire logic [QW-1:0] addr,
  output logic [QW-1:0] flag_idx,
  output logic [QW-1:0] port_idx
);
  logic [QW-1:0] stage_q [SEL_PORT_EDGES];
  logic [SEL_PORT_EDGES-1:0] pend_q;

  // The flag source moves one edge after the request so that the two flag
  // register stages deliver the new status on the third edge.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_q <= '0;
      for (int i = 0; i < SEL_PORT_EDGES; i++) begin
        stage_q[i] <= '0;
      end
    end else if (tick) begin
      pend_q <= {pend_q[SEL_PORT_EDGES-2:0], strobe};
      stage_q[0] <= strobe ? addr : stage_q[0];
      for (int i = 1; i < SEL_PORT_EDGES; i++) begin
        if (pend_q[i-1]) begin
          stage_q[i] <= stage_q[i-1];
        end
      end
    end
  end

  assign flag_idx = stage_q[SEL_FLAG_EDGES];
  assign port_idx = stage_q[SEL_PORT_EDGES-1];
endmodule : mqaf_qsel
`default_nettype wire

// *** mqaf_flag_out.sv ***
// Double-registered active-queue flag with delayed deassertion.
// Assumes raw holds the live condition of every queue and tick marks the port edge.
`timescale 1ns/1ps
`default_nettype none
module mqaf_flag_out
  import mqaf_pkg::*;
#(
  parameter int unsigned NQ = NUM_QUEUES,
  parameter int unsigned QW = QSEL_W,
  parameter bit EXTRA = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic skew_late,
  input wire logic [NQ-1:0] raw,
  input wire logic [QW-1:0] idx,
  output logic flag_n,
  output logic [BUS_GROUP-1:0] bus_n,
  output logic assert_ev
);
  logic [NQ-1:0] hold1_q;
  logic [NQ-1:0] hold2_q;
  logic [NQ-1:0] eff;
  logic stage_q;
  logic [QW-1:0] grp_base;

  // Assertion passes at once; release is held back by the extra edges.
  always_comb begin
    eff = raw;
    if (EXTRA) begin
      eff = eff | hold1_q;
    end
    if (skew_late) begin
      eff = eff | (EXTRA ? hold2_q : hold1_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold1_q <= '0;
      hold2_q <= '0;
    end else if (tick) begin
      hold1_q <= raw;
      hold2_q <= hold1_q;
    end
  end

  assign grp_base = idx & ~QW'(BUS_GROUP - 1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage_q <= 1'b0;
      flag_n <= 1'b1;
      bus_n <= '1;
      assert_ev <= 1'b0;
    end else begin
      assert_ev <= 1'b0;
      if (tick) begin
        stage_q <= eff[idx];
        flag_n <= ~stage_q;
        assert_ev <= stage_q & flag_n;
        for (int b = 0; b < BUS_GROUP; b++) begin
          bus_n[b] <= ~eff[grp_base + QW'(b)];
        end
      end
    end
  end
endmodule : mqaf_flag_out
`default_nettype wire

// *** mqaf_top.sv ***
// Almost-full and almost-empty flag logic for a multi-queue buffer.
// Assumes one 50 MHz clock; write and read port edges arrive as tick enables.
// Summary of operation
// RL1: Track almost-full per queue; show active write queue.
// RL2: Offsets programmed, or default 8 or 128.
// RL3: Almost-full offset 0 to depth, per queue.
// RL4: New write queue flag on third edge.
// RL5: Almost-full goes low two write edges after write.
// RL6: Almost-full released two write edges after read.
// RL7: Skew miss adds one write edge to release.
// RL8: Almost-full changes only on write edges.
// RL9: Reads update any queue's almost-full state.
// RL10: Track almost-empty per queue; show active read queue.
// RL11: Almost-empty offset 0 to depth, per queue.
// RL12: New read queue flag on third edge.
// RL13: Almost-empty goes low two read edges after read.
// RL14: Almost-empty released three read edges after write.
// RL15: Skew miss adds one read edge to release.
// RL16: Almost-empty changes only on read edges.
// RL17: Writes update any queue's almost-empty state.
// RL18: Active flags copied onto status buses.
// RL19: Threshold compare: at or below offset.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mqaf_top
  import mqaf_pkg::*;
#(
  parameter int unsigned NQ = NUM_QUEUES,
  parameter int unsigned DEPTH = QUEUE_DEPTH
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic W_TICK,
  input wire logic WRITE_EN,
  input wire logic [QSEL_W-1:0] WRITE_QUEUE_SELECT_BUS,
  input wire logic WRITE_SELECT_STROBE,
  input wire logic R_TICK,
  input wire logic READ_EN,
  input wire logic [QSEL_W-1:0] READ_QUEUE_SELECT_BUS,
  input wire logic READ_SELECT_STROBE,
  input wire logic SKEW_W_LATE,
  input wire logic SKEW_R_LATE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic ALMOST_FULL_N,
  output logic ALMOST_EMPTY_N,
  output logic [BUS_GROUP-1:0] ALMOST_FULL_BUS_N,
  output logic [BUS_GROUP-1:0] ALMOST_EMPTY_BUS_N,
  output logic IRQ
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [CW-1:0] mqaf_clamp(input logic [PROG_VALUE_W-1:0] v);
    mqaf_clamp = (v > PROG_VALUE_W'(DEPTH)) ? DEPTH_C : CW'(v);
  endfunction : mqaf_clamp

  function automatic logic [CW-1:0] mqaf_step(input logic [CW-1:0] c, input logic inc,
                                              input logic dec);
    mqaf_step = c + CW'(inc) - CW'(dec);
  endfunction : mqaf_step

  ////////////////////////////////////////////////////////////////////////////
  // Queue selection on both ports.

  logic [QSEL_W-1:0] wr_flag_idx;
  logic [QSEL_W-1:0] wr_port_idx;
  logic [QSEL_W-1:0] rd_flag_idx;
  logic [QSEL_W-1:0] rd_port_idx;

  mqaf_qsel #(.QW(QSEL_W)) u_wsel ( // RL4
    .clk(CLK),
    .nrst(NRST),
    .tick(W_TICK),
    .strobe(WRITE_SELECT_STROBE),
    .addr(WRITE_QUEUE_SELECT_BUS),
    .flag_idx(wr_flag_idx),
    .port_idx(wr_port_idx)
  );

  mqaf_qsel #(.QW(QSEL_W)) u_rsel ( // RL12
    .clk(CLK),
    .nrst(NRST),
    .tick(R_TICK),
    .strobe(READ_SELECT_STROBE),
    .addr(READ_QUEUE_SELECT_BUS),
    .flag_idx(rd_flag_idx),
    .port_idx(rd_port_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Offsets per queue.

  logic [CW-1:0] af_off_q [NQ];
  logic [CW-1:0] ae_off_q [NQ];
  logic def_sel_q;
  logic wr_ctrl;
  logic wr_prog;
  logic [QSEL_W-1:0] prog_q;
  logic [CW-1:0] prog_val;
  logic [CW-1:0] def_val;

  assign wr_ctrl = REG_WR && REG_ADDR == REG_CTRL;
  assign wr_prog = REG_WR && REG_ADDR == REG_PROG;
  assign prog_q = REG_WDATA[PROG_QUEUE_LSB +: QSEL_W];
  assign prog_val = mqaf_clamp(REG_WDATA[PROG_VALUE_LSB +: PROG_VALUE_W]);
  assign def_val = mqaf_clamp(REG_WDATA[CTRL_DEF_SEL_BIT] ? DEF_OFFSET_LARGE
                                                          : DEF_OFFSET_SMALL);

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      def_sel_q <= 1'b0;
    end else if (wr_ctrl) begin
      def_sel_q <= REG_WDATA[CTRL_DEF_SEL_BIT];
    end
  end

  // Offsets are clamped to the queue depth; each queue keeps its own pair.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      for (int q = 0; q < NQ; q++) begin
        af_off_q[q] <= mqaf_clamp(DEF_OFFSET_SMALL); // RL2
        ae_off_q[q] <= mqaf_clamp(DEF_OFFSET_SMALL); // RL2
      end
    end else if (wr_ctrl && REG_WDATA[CTRL_LOAD_BIT]) begin
      for (int q = 0; q < NQ; q++) begin
        af_off_q[q] <= def_val; // RL2
        ae_off_q[q] <= def_val; // RL2
      end
    end else if (wr_prog && 32'(prog_q) < NQ) begin
      if (REG_WDATA[PROG_KIND_BIT]) begin
        ae_off_q[prog_q] <= prog_val; // RL11
      end else begin
        af_off_q[prog_q] <= prog_val; // RL3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word counts per queue.

  logic [CW-1:0] cnt_q [NQ];
  logic do_wr;
  logic do_rd;

  assign do_wr = W_TICK && WRITE_EN && cnt_q[wr_port_idx] != DEPTH_C;
  assign do_rd = R_TICK && READ_EN && cnt_q[rd_port_idx] != '0;

  // Writes and reads change the count of any queue, selected for flags or not.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      for (int q = 0; q < NQ; q++) begin
        cnt_q[q] <= '0;
      end
    end else begin
      for (int q = 0; q < NQ; q++) begin
        cnt_q[q] <= mqaf_step(cnt_q[q], do_wr && wr_port_idx == QSEL_W'(q), // RL17
                              do_rd && rd_port_idx == QSEL_W'(q)); // RL9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live conditions and active flags.

  logic [NQ-1:0] af_raw;
  logic [NQ-1:0] ae_raw;

  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      af_raw[q] = (DEPTH_C - cnt_q[q]) <= af_off_q[q]; // RL19 RL1
      ae_raw[q] = cnt_q[q] <= ae_off_q[q]; // RL19 RL10
    end
  end

  logic af_ev;
  logic ae_ev;

  mqaf_flag_out #(.NQ(NQ), .QW(QSEL_W), .EXTRA(1'b0)) u_af ( // RL5 RL6 RL7 RL8 RL18
    .clk(CLK),
    .nrst(NRST),
    .tick(W_TICK),
    .skew_late(SKEW_W_LATE),
    .raw(af_raw),
    .idx(wr_flag_idx),
    .flag_n(ALMOST_FULL_N),
    .bus_n(ALMOST_FULL_BUS_N),
    .assert_ev(af_ev)
  );

  mqaf_flag_out #(.NQ(NQ), .QW(QSEL_W), .EXTRA(1'b1)) u_ae ( // RL13 RL14 RL15 RL16 RL18
    .clk(CLK),
    .nrst(NRST),
    .tick(R_TICK),
    .skew_late(SKEW_R_LATE),
    .raw(ae_raw),
    .idx(rd_flag_idx),
    .flag_n(ALMOST_EMPTY_N),
    .bus_n(ALMOST_EMPTY_BUS_N),
    .assert_ev(ae_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, clear and enable.

  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] enable_q;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign ev_set = {ae_ev, af_ev};
  assign ev_clr = (REG_WR && REG_ADDR == REG_CLEAR) ? REG_WDATA[EV_W-1:0] : '0;

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      enable_q <= '0;
    end else if (REG_WR && REG_ADDR == REG_ENABLE) begin
      enable_q <= REG_WDATA[EV_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((status_q & ~ev_clr) | ev_set) & enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= '0;
      if (REG_RD) begin
        unique case (REG_ADDR)
          REG_CTRL: REG_RDATA <= 32'(def_sel_q);
          REG_STATUS: REG_RDATA <= 32'(status_q);
          REG_ENABLE: REG_RDATA <= 32'(enable_q);
          REG_LEVEL: REG_RDATA <= {17'h00000, rd_port_idx, 3'h0, wr_port_idx,
                                   ALMOST_EMPTY_N, ALMOST_FULL_N};
          default: REG_RDATA <= '0;
        endcase
      end
    end
  end
endmodule : mqaf_top
`default_nettype wire

// *** mqaf_ctrl_model.sv ***
// Controller model: makes write and read port edges, gates bench requests onto them.
// Assumes the bench changes the on levels just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module mqaf_ctrl_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] on,
  output logic w_tick,
  output logic r_tick,
  output logic write_en,
  output logic read_en,
  output logic wsel_strobe,
  output logic rsel_strobe
);
  logic [1:0] rc_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      w_tick <= 1'b0;
      r_tick <= 1'b0;
      rc_q <= 2'h0;
    end else begin
      w_tick <= !w_tick;
      rc_q <= (rc_q == 2'h2) ? 2'h0 : rc_q + 2'h1;
      r_tick <= (rc_q == 2'h2);
    end
  end
  // A select is qualified by its own port's edges, for as long as its on level is held.
  assign write_en = w_tick & on[0];
  assign read_en = r_tick & on[1];
  assign wsel_strobe = w_tick & on[2];
  assign rsel_strobe = r_tick & on[3];
endmodule : mqaf_ctrl_model
`default_nettype wire

// *** mqaf_top_assertions.sv ***
// Checker for the almost-flag block, bound to its top module.
// Assumes port edges arrive as one-cycle tick enables.
`timescale 1ns/1ps
`default_nettype none
module mqaf_top_checker
  import mqaf_pkg::*;
#(
  parameter int unsigned NQ = NUM_QUEUES,
  parameter int unsigned DEPTH = QUEUE_DEPTH
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic W_TICK,
  input wire logic WRITE_EN,
  input wire logic WRITE_SELECT_STROBE,
  input wire logic R_TICK,
  input wire logic READ_EN,
  input wire logic READ_SELECT_STROBE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic ALMOST_FULL_N,
  input wire logic ALMOST_EMPTY_N,
  input wire logic [BUS_GROUP-1:0] ALMOST_FULL_BUS_N,
  input wire logic [BUS_GROUP-1:0] ALMOST_EMPTY_BUS_N,
  input wire logic IRQ
);
  logic [2:0] wh_q, rh_q;
  logic [3:0] ws_q, rs_q, cf_q;
  logic [1:0] en_q;
  // Per-port history of operations, shifted on that port's edges.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wh_q <= 3'h0;
      rh_q <= 3'h0;
      ws_q <= 4'h0;
      rs_q <= 4'h0;
      en_q <= 2'h0;
    end else begin
      if (W_TICK) wh_q <= {wh_q[1:0], WRITE_EN};
      if (W_TICK) ws_q <= {ws_q[2:0], WRITE_SELECT_STROBE};
      if (R_TICK) rh_q <= {rh_q[1:0], READ_EN};
      if (R_TICK) rs_q <= {rs_q[2:0], READ_SELECT_STROBE};
      if (REG_WR && REG_ADDR == REG_ENABLE) en_q <= REG_WDATA[1:0];
    end
  end
  // Reset or reprogramming may legally move flags for a few edges.
  always_ff @(posedge CLK) begin
    if (!NRST || REG_WR) cf_q <= 4'h8;
    else if (W_TICK && cf_q != 4'h0) cf_q <= cf_q - 4'h1;
  end
  af_wr_edge_a: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(ALMOST_FULL_N) |-> $past(W_TICK)) else $error("almost-full moved off edge");
  ae_rd_edge_a: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(ALMOST_EMPTY_N) |-> $past(R_TICK)) else $error("almost-empty moved off edge");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (!NRST)
    !$past(REG_RD) |-> REG_RDATA == 32'h0) else $error("read data outside read slot");
  af_fall_cause_a: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(ALMOST_FULL_N) |-> wh_q[2] || ws_q[3] || cf_q != 4'h0) else $error("bad af fall");
  ae_fall_cause_a: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(ALMOST_EMPTY_N) |-> rh_q[2] || rs_q[3] || cf_q != 4'h0) else $error("bad ae fall");
  irq_masked_a: assert property (@(posedge CLK) disable iff (!NRST)
    (en_q == 2'h0) [*2] |-> !IRQ) else $error("interrupt while disabled");
  af_bus_copy_a: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(ALMOST_FULL_N) |-> ##[0:4] !(&ALMOST_FULL_BUS_N)) else $error("af bus not low");
  ae_bus_copy_a: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(ALMOST_EMPTY_N) |-> ##[0:4] !(&ALMOST_EMPTY_BUS_N)) else $error("ae bus not low");
endmodule : mqaf_top_checker
bind mqaf_top mqaf_top_checker #(.NQ(NQ), .DEPTH(DEPTH)) mqaf_top_checker_i (.*);
`default_nettype wire

// *** mqaf_top_bench.sv ***
// Self-checking bench for the almost-flag block; flags are read back via the level register.
// Assumes the controller model makes the port edges.
`timescale 1ns/1ps
`default_nettype none
module mqaf_top_bench;
  import mqaf_pkg::*;
  localparam int DP = 16;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [3:0] on = 4'h0;
  logic [3:0] ad = 4'h0;
  logic [4:0] wbus = 5'h0, rbus = 5'h0;
  logic skw = 1'b0, skr = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [31:0] wd = 32'h0, lf = 32'hf3e1;
  logic w_tick, r_tick, wen, ren, wst, rst_s;
  logic [31:0] rdata;
  logic af_n, ae_n, irq;
  logic [BUS_GROUP-1:0] fb, eb;
  logic [31:0] exp_q[$];
  int err_count = 0, samples_checked = 0, tn = 0, wq = 0, rq = 0;
  int cnt[NUM_QUEUES], afo[NUM_QUEUES], aeo[NUM_QUEUES];
  always #10 CLK = ~CLK;
  mqaf_ctrl_model mqaf_ctrl_model_i (.clk(CLK), .nrst(NRST), .on(on), .w_tick(w_tick),
    .r_tick(r_tick), .write_en(wen), .read_en(ren), .wsel_strobe(wst), .rsel_strobe(rst_s));
  mqaf_top #(.DEPTH(DP)) mqaf_top_i (.CLK(CLK), .NRST(NRST), .W_TICK(w_tick), .WRITE_EN(wen),
    .WRITE_QUEUE_SELECT_BUS(wbus), .WRITE_SELECT_STROBE(wst), .R_TICK(r_tick), .READ_EN(ren),
    .READ_QUEUE_SELECT_BUS(rbus), .READ_SELECT_STROBE(rst_s), .SKEW_W_LATE(skw),
    .SKEW_R_LATE(skr), .REG_ADDR(ad), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .ALMOST_FULL_N(af_n), .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_BUS_N(fb),
    .ALMOST_EMPTY_BUS_N(eb), .IRQ(irq));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [31:0] lev();
    logic af, ae;
    af = (DP - cnt[wq]) > afo[wq];
    ae = cnt[rq] > aeo[rq];
    return {17'h0, rq[4:0], 3'h0, wq[4:0], ae, af};
  endfunction : lev
  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge CLK);
    wr <= 1'b0;
  endtask : rw
  task automatic rr(input logic [3:0] a, input logic [31:0] e);
    @(posedge CLK);
    exp_q.push_back(e);
    rd <= 1'b1;
    ad <= a;
    @(posedge CLK);
    rd <= 1'b0;
  endtask : rr
  // k: 0 write, 1 read, 2 write select, 3 read select; n port edges with the request.
  // A select waits two more port edges, so the next transfer meets the new queue.
  task automatic act(input int k, input int n, input int q);
    int c = 0;
    int m;
    m = (k >= 2) ? n + 2 : n;
    @(posedge CLK);
    on[k] <= 1'b1;
    if (k == 2) wbus <= q[4:0];
    if (k == 3) rbus <= q[4:0];
    while (c < m) begin
      @(posedge CLK);
      if (((k % 2 == 0) ? w_tick : r_tick) === 1'b1) c++;
      if (c == n) on[k] <= 1'b0;
    end
    if (k == 0) cnt[wq] = (cnt[wq] + n > DP) ? DP : cnt[wq] + n;
    if (k == 1) cnt[rq] = (cnt[rq] < n) ? 0 : cnt[rq] - n;
    if (k == 2) wq = q;
    if (k == 3) rq = q;
  endtask : act
  task automatic chk();
    logic [31:0] v;
    lf = nxt(lf);
    skw <= lf[0];
    skr <= lf[1];
    repeat (24) @(posedge CLK);
    v = lev();
    cmp_bit(af_n, v[0]);
    cmp_bit(ae_n, v[1]);
    cmp_bit(fb[wq[2:0]], v[0]);
    cmp_bit(eb[rq[2:0]], v[1]);
    rr(REG_LEVEL, v);
  endtask : chk
  task automatic cmp_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: flag %b, want %b", $time, g, e);
    end
  endtask : cmp_bit
  task automatic cmp(input logic [31:0] e);
    samples_checked++;
    if (rdata !== e) begin
      err_count++;
      $display("unexpected at %0t: read %h, want %h", $time, rdata, e);
    end
  endtask : cmp
  task automatic fin();
    tn++;
    $display("test %0d done", tn);
  endtask : fin
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  always @(posedge CLK) begin
    if (rd_d) cmp(exp_q.pop_front());
    rd_d <= rd;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    wrap_up();
  end
  initial begin
    foreach (cnt[i]) begin
      cnt[i] = 0;
      afo[i] = 8;
      aeo[i] = 8;
    end
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    rr(REG_CTRL, 32'h0);
    rr(REG_ENABLE, 32'h0);
    rr(4'hf, 32'h0);
    chk();
    rw(REG_ENABLE, 32'h3);
    rr(REG_STATUS, 32'h2);
    cmp_bit(irq, 1'b1);
    rw(REG_CLEAR, 32'h3);
    rr(REG_STATUS, 32'h0);
    cmp_bit(irq, 1'b0);
    fin();
    act(0, 9, 0);
    chk();
    rr(REG_STATUS, 32'h1);
    rw(REG_CLEAR, 32'h3);
    rw(REG_ENABLE, 32'h0);
    fin();
    act(2, 1, 1);
    chk();
    act(1, 2, 0);
    chk();
    act(2, 1, 0);
    chk();
    fin();
    rw(REG_PROG, 32'h0000_0001);
    afo[1] = 0;
    rw(REG_PROG, 32'h0002_0101);
    aeo[1] = 2;
    act(2, 1, 1);
    act(0, 15, 0);
    chk();
    act(0, 1, 0);
    chk();
    act(3, 1, 1);
    chk();
    act(1, 14, 0);
    chk();
    fin();
    act(2, 1, 0);
    act(3, 1, 0);
    act(0, 5, 0);
    for (int s = 1; s >= 0; s--) begin
      rw(REG_CTRL, 32'h2 | s);
      foreach (afo[i]) begin
        afo[i] = s ? 128 : 8;
        aeo[i] = afo[i];
      end
      chk();
      fin();
    end
    wrap_up();
  end
endmodule : mqaf_top_bench
`default_nettype wire
